/* File: hdl/channel_powerdown_consts.vh */
// constants for the channel power-down and extra-lane control block
// assumes a 32-bit ahb-lite register bus, one word per register index
`ifndef CHANNEL_POWERDOWN_CONSTS_VH
`define CHANNEL_POWERDOWN_CONSTS_VH

// ----------------------------------------
// register indices, byte address = 4 * index
// ----------------------------------------
`define IDX_CHANNEL_POWER_DOWN 10'h209
`define IDX_EXTRA_LANE_A 10'h20a
`define IDX_LINK_CONFIG 10'h20c
`define IDX_LANE_REQUIRED_A 10'h20d
`define IDX_BLOCK_STATUS 10'h20e

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_CHANNEL_POWER_DOWN 8'h00
`define RST_EXTRA_LANE_A 8'h00
`define RST_LINK_CONFIG 18'h00000
`define RST_LANE_REQUIRED_A 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define PD_CHAN_A_BIT 0
`define PD_CHAN_B_BIT 1
`define EXTRA_SER_BIT 0
`define LINKCFG_ENABLE_BIT 0
`define LINKCFG_PATTERN_LSB 4
`define LINKCFG_PATTERN_MSB 7
`define LINKCFG_MODE_LSB 8
`define LINKCFG_MODE_MSB 15
`define LINKCFG_BIND_A_BIT 16
`define LINKCFG_BIND_B_BIT 17

// ----------------------------------------
// test pattern codes
// ----------------------------------------
`define PATTERN_NORMAL 4'h0
`define PATTERN_RAMP 4'h4
`define PATTERN_ALT_RAMP_CASE 4'h5

// ----------------------------------------
// ahb encodings
// ----------------------------------------
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'h0

`endif

/* File: hdl/lane_enable_cell.v */
// one output lane: clock, serializer and ramp decisions
// assumes purely combinational use, results registered by the caller
`timescale 1ns/1ps
`default_nettype none

module lane_enable_cell (
  input wire laneRequired,
  input wire laneExtra,
  input wire extraSerEnable,
  input wire linkActive,
  input wire lowerSerOk,
  input wire patternWantsRamp,
  output wire linkClkEn,
  output wire serClkOk,
  output wire serEn,
  output wire rampSel
);
  // ----------------------------------------
  // lane decisions
  // ----------------------------------------
  assign linkClkEn = (laneRequired | laneExtra) & linkActive;
  assign serClkOk = linkClkEn & lowerSerOk;
  assign serEn = serClkOk & (laneRequired | (laneExtra & extraSerEnable));
  assign rampSel = linkClkEn & laneExtra & ~laneRequired & patternWantsRamp;
endmodule // lane_enable_cell

`default_nettype wire

/* File: hdl/channel_powerdown_extra_lane_ctl.v */
// channel power-down and link a extra-lane control with ahb-lite slave
// assumes one clock, synchronous active-low reset, single word transfers
`timescale 1ns/1ps
`default_nettype none
`include "channel_powerdown_consts.vh"

module channel_powerdown_extra_lane_ctl (
  input wire clk,
  input wire resetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  output reg convAPowerDown,
  output reg convBPowerDown,
  output reg digAPowerDown,
  output reg digBPowerDown,
  output reg linkSubsysPowerDown,
  output reg bSlotsUndefined,
  output reg linkEnable,
  output reg [7:0] linkModeSelect,
  output reg [3:0] linkTestPatternSelect,
  output reg [7:0] laneClkEnA,
  output reg [7:0] serEnA,
  output reg [7:0] laneRampA,
  output reg [31:0] lanePatternA
);

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  reg [7:0] channelPowerDown_reg;
  reg [7:0] channelPowerDown_next;
  reg [7:0] extraLaneA_reg;
  reg [7:0] extraLaneA_next;
  reg [17:0] linkConfig_reg;
  reg [17:0] linkConfig_next;
  reg [7:0] laneRequiredA_reg;
  reg [7:0] laneRequiredA_next;

  // ----------------------------------------
  // bus phase tracking
  // ----------------------------------------
  // one-hot data phase state
  localparam [2:0] PHASE_IDLE = 3'h1;
  localparam [2:0] PHASE_WRITE = 3'h2;
  localparam [2:0] PHASE_READ = 3'h4;
  reg [2:0] phase_reg;
  reg [2:0] phase_next;
  reg [9:0] wrIdx_reg;
  reg [9:0] wrIdx_next;
  reg [31:0] rdData_next;
  wire addrPhase;
  wire [9:0] addrIdx;
  wire [31:0] statusWord;
  wire writeLands;

  assign addrPhase = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
  assign addrIdx = haddr[11:2];
  // write data taken at the edge that ends its data phase
  assign writeLands = (phase_reg == PHASE_WRITE) & hready;

  // ----------------------------------------
  // power state decode
  // ----------------------------------------
  wire pdA;
  wire pdB;
  wire bindAToB;
  wire bindBToA;
  wire digADown;
  wire digBDown;
  wire subsysDown;
  wire linkADown;
  wire linkAActive;
  wire [3:0] patternSel;
  wire patternWantsRamp;

  assign pdA = channelPowerDown_reg[`PD_CHAN_A_BIT];
  assign pdB = channelPowerDown_reg[`PD_CHAN_B_BIT];
  assign bindAToB = linkConfig_reg[`LINKCFG_BIND_A_BIT];
  assign bindBToA = linkConfig_reg[`LINKCFG_BIND_B_BIT];
  // digital channel follows the converter it is bound to
  assign digADown = bindAToB ? pdB : pdA;
  assign digBDown = bindBToA ? pdA : pdB;
  // both converters off drops the whole serial subsystem
  assign subsysDown = pdA & pdB;
  // link a lives on digital a; digital b alone does not stop it
  assign linkADown = subsysDown | digADown;
  assign linkAActive = ~linkADown & linkConfig_reg[`LINKCFG_ENABLE_BIT];
  assign patternSel = linkConfig_reg[`LINKCFG_PATTERN_MSB:`LINKCFG_PATTERN_LSB];
  assign patternWantsRamp = (patternSel == `PATTERN_NORMAL) |
                            (patternSel == `PATTERN_ALT_RAMP_CASE);

  // ----------------------------------------
  // lane decisions
  // ----------------------------------------
  wire [7:0] extraVec;
  wire [8:0] serChain;
  wire [7:0] laneClkEnNext;
  wire [7:0] serEnNext;
  wire [7:0] rampNext;
  wire [31:0] lanePatternNext;

  // lane 0 is never an extra lane; field covers lanes 1 to 7
  assign extraVec = {extraLaneA_reg[7:1], 1'b0};
  assign serChain[0] = 1'b1;

  genvar lane;
  generate
    for (lane = 0; lane < 8; lane = lane + 1) begin : gLane
      lane_enable_cell uCell (
        .laneRequired(laneRequiredA_reg[lane]),
        .laneExtra(extraVec[lane]),
        .extraSerEnable(extraLaneA_reg[`EXTRA_SER_BIT]),
        .linkActive(linkAActive),
        .lowerSerOk(serChain[lane]),
        .patternWantsRamp(patternWantsRamp),
        .linkClkEn(laneClkEnNext[lane]),
        .serClkOk(serChain[lane+1]),
        .serEn(serEnNext[lane]),
        .rampSel(rampNext[lane])
      );
      // clocked extra-only lanes swap to the ramp under pattern 0 or 5, others follow the selection
      assign lanePatternNext[4*lane+3:4*lane] = rampNext[lane] ? `PATTERN_RAMP :
                                                 patternSel;
    end
  endgenerate

  // ----------------------------------------
  // status word
  // ----------------------------------------
  assign statusWord = {laneRampA, serEnA, laneClkEnA, 2'h0, bSlotsUndefined,
                       linkSubsysPowerDown, digBPowerDown, digAPowerDown,
                       convBPowerDown, convAPowerDown};

  // ----------------------------------------
  // register write path
  // ----------------------------------------
  always @* begin
    channelPowerDown_next = channelPowerDown_reg;
    extraLaneA_next = extraLaneA_reg;
    linkConfig_next = linkConfig_reg;
    laneRequiredA_next = laneRequiredA_reg;
    if (writeLands) begin
      case (wrIdx_reg)
        `IDX_CHANNEL_POWER_DOWN: begin
          // reserved bits stored as written
          channelPowerDown_next = hwdata[7:0];
        end
        `IDX_EXTRA_LANE_A: begin
          extraLaneA_next = hwdata[7:0];
        end
        `IDX_LINK_CONFIG: begin
          linkConfig_next = hwdata[17:0];
        end
        `IDX_LANE_REQUIRED_A: begin
          laneRequiredA_next = hwdata[7:0];
        end
        default: begin
          channelPowerDown_next = channelPowerDown_reg;
        end
      endcase
    end
  end

  // ----------------------------------------
  // address phase capture and read mux
  // ----------------------------------------
  always @* begin
    wrIdx_next = addrPhase ? addrIdx : wrIdx_reg;
    rdData_next = 32'h00000000;
    if (addrPhase & ~hwrite) begin
      case (addrIdx)
        `IDX_CHANNEL_POWER_DOWN: begin
          rdData_next = {24'h000000, channelPowerDown_reg};
        end
        `IDX_EXTRA_LANE_A: begin
          rdData_next = {24'h000000, extraLaneA_reg};
        end
        `IDX_LINK_CONFIG: begin
          rdData_next = {14'h0000, linkConfig_reg};
        end
        `IDX_LANE_REQUIRED_A: begin
          rdData_next = {24'h000000, laneRequiredA_reg};
        end
        `IDX_BLOCK_STATUS: begin
          rdData_next = statusWord;
        end
        default: begin
          rdData_next = 32'h00000000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // data phase state machine
  // ----------------------------------------
  always @* begin
    phase_next = PHASE_IDLE;
    case (phase_reg)
      PHASE_IDLE, PHASE_WRITE, PHASE_READ: begin
        if (!hready) begin
          // a stalled data phase keeps its state
          phase_next = phase_reg;
        end else if (addrPhase & hwrite) begin
          phase_next = PHASE_WRITE;
        end else if (addrPhase) begin
          phase_next = PHASE_READ;
        end else begin
          phase_next = PHASE_IDLE;
        end
      end
      default: begin
        phase_next = PHASE_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // register flops
  // ----------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      channelPowerDown_reg <= `RST_CHANNEL_POWER_DOWN;
      extraLaneA_reg <= `RST_EXTRA_LANE_A;
      linkConfig_reg <= `RST_LINK_CONFIG;
      laneRequiredA_reg <= `RST_LANE_REQUIRED_A;
      phase_reg <= PHASE_IDLE;
      wrIdx_reg <= 10'h000;
    end else begin
      channelPowerDown_reg <= channelPowerDown_next;
      extraLaneA_reg <= extraLaneA_next;
      linkConfig_reg <= linkConfig_next;
      laneRequiredA_reg <= laneRequiredA_next;
      phase_reg <= phase_next;
      wrIdx_reg <= wrIdx_next;
    end
  end

  // ----------------------------------------
  // bus response flops
  // ----------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
    end else begin
      hrdata <= rdData_next;
      // zero wait states, every answer okay
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
    end
  end

  // ----------------------------------------
  // registered control outputs
  // ----------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      convAPowerDown <= 1'b0;
      convBPowerDown <= 1'b0;
      digAPowerDown <= 1'b0;
      digBPowerDown <= 1'b0;
      linkSubsysPowerDown <= 1'b0;
      bSlotsUndefined <= 1'b0;
      linkEnable <= 1'b0;
      linkModeSelect <= 8'h00;
      linkTestPatternSelect <= 4'h0;
    end else begin
      convAPowerDown <= pdA;
      convBPowerDown <= pdB;
      digAPowerDown <= digADown;
      digBPowerDown <= digBDown;
      linkSubsysPowerDown <= subsysDown;
      // link a up while digital b is off: b sample slots carry junk
      bSlotsUndefined <= digBDown & ~linkADown;
      linkEnable <= linkConfig_reg[`LINKCFG_ENABLE_BIT] & ~subsysDown;
      linkModeSelect <= linkConfig_reg[`LINKCFG_MODE_MSB:`LINKCFG_MODE_LSB];
      linkTestPatternSelect <= patternSel;
    end
  end

  // ----------------------------------------
  // registered lane outputs
  // ----------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      laneClkEnA <= 8'h00;
      serEnA <= 8'h00;
      laneRampA <= 8'h00;
      lanePatternA <= 32'h00000000;
    end else begin
      laneClkEnA <= laneClkEnNext;
      serEnA <= serEnNext;
      laneRampA <= rampNext;
      lanePatternA <= lanePatternNext;
    end
  end

endmodule // channel_powerdown_extra_lane_ctl

`default_nettype wire

/* File: tb/cpd_checker_assertions.sv */
// checker: output relations of the power-down and lane block
// assumes bind onto the control block, ports only
`timescale 1ns/1ps
`default_nettype none
module cpd_checker (
  input wire clk,
  input wire resetn,
  input wire hsel,
  input wire hready,
  input wire hwrite,
  input wire [1:0] htrans,
  input wire [31:0] haddr,
  input wire [31:0] hwdata,
  input wire hreadyout,
  input wire convAPowerDown,
  input wire convBPowerDown,
  input wire digAPowerDown,
  input wire digBPowerDown,
  input wire linkSubsysPowerDown,
  input wire bSlotsUndefined,
  input wire linkEnable,
  input wire [3:0] linkTestPatternSelect,
  input wire [7:0] laneClkEnA,
  input wire [7:0] serEnA,
  input wire [7:0] laneRampA,
  input wire [31:0] lanePatternA
);
  logic [7:0] pre;
  logic [7:0] rampBad;
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      pre[n] = &(laneClkEnA | ~(8'hff >> (7 - n)));
      rampBad[n] = laneRampA[n] && lanePatternA[4*n+:4] != 4'h4;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_sub; linkSubsysPowerDown == (convAPowerDown && convBPowerDown); endproperty
  a_sub: assert property (p_sub) else $error("subsystem state wrong");
  property p_len; linkSubsysPowerDown |-> !linkEnable && laneClkEnA == 8'h0; endproperty
  a_len: assert property (p_len) else $error("link alive while down");
  property p_ser; (serEnA & ~laneClkEnA) == 8'h0; endproperty
  a_ser: assert property (p_ser) else $error("serializer without clock");
  property p_chain; (serEnA & ~pre) == 8'h0; endproperty
  a_chain: assert property (p_chain) else $error("serializer chain broken");
  property p_diga; digAPowerDown |-> laneClkEnA == 8'h0 && serEnA == 8'h0; endproperty
  a_diga: assert property (p_diga) else $error("lanes on with a down");
  property p_ramp; laneRampA != 8'h0 |->
    (linkTestPatternSelect == 4'h0 || linkTestPatternSelect == 4'h5) && rampBad == 8'h0;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp lane wrong");
  property p_bind; digAPowerDown |-> convAPowerDown || convBPowerDown; endproperty
  a_bind: assert property (p_bind) else $error("digital down without cause");
  property p_bs; bSlotsUndefined |-> digBPowerDown && !digAPowerDown && !linkSubsysPowerDown;
  endproperty
  a_bs: assert property (p_bs) else $error("b slots flag wrong");
  property p_wr; (hsel && hready && htrans[1] && hwrite && haddr[11:2] == 10'h209) ##1 1
    |-> ##2 convAPowerDown == $past(hwdata[0], 2); endproperty
  a_wr: assert property (p_wr) else $error("channel a power-down not applied");
endmodule // cpd_checker
bind channel_powerdown_extra_lane_ctl cpd_checker u_chk (.clk(clk), .resetn(resetn),
  .hsel(hsel), .hready(hready), .hwrite(hwrite), .htrans(htrans), .haddr(haddr),
  .hwdata(hwdata), .hreadyout(hreadyout), .convAPowerDown(convAPowerDown),
  .convBPowerDown(convBPowerDown), .digAPowerDown(digAPowerDown),
  .digBPowerDown(digBPowerDown), .linkSubsysPowerDown(linkSubsysPowerDown),
  .bSlotsUndefined(bSlotsUndefined), .linkEnable(linkEnable),
  .linkTestPatternSelect(linkTestPatternSelect), .laneClkEnA(laneClkEnA),
  .serEnA(serEnA), .laneRampA(laneRampA), .lanePatternA(lanePatternA));
`default_nettype wire

/* File: tb/tb_top.sv */
// bench: register access and lane decisions, random and corner cases
// assumes the consts header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "channel_powerdown_consts.vh"
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); end end
module tb_top;
  logic clk = 0, resetn = 0, hsel = 1, hwrite = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, rdq;
  wire hready, hresp, cA, cB, dA, dB, sub, bs, len;
  wire [7:0] lms, ck, se, rp;
  wire [3:0] lts;
  wire [31:0] hrdata, lpat;
  int errors = 0, n_compared = 0;
  always #2 clk = ~clk;
  always @(posedge clk) rdq <= hrdata;
  channel_powerdown_extra_lane_ctl dut (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready),
    .hwdata(hwdata), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .convAPowerDown(cA), .convBPowerDown(cB), .digAPowerDown(dA), .digBPowerDown(dB),
    .linkSubsysPowerDown(sub), .bSlotsUndefined(bs), .linkEnable(len),
    .linkModeSelect(lms), .linkTestPatternSelect(lts), .laneClkEnA(ck), .serEnA(se),
    .laneRampA(rp), .lanePatternA(lpat));
  // ----
  // bus master and verdict
  // ----
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    int i;
    @(posedge clk);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, idx, 2'h0};
    i = 0;
    do begin @(posedge clk); i++; end while (hready !== 1'b1 && i < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); i++; end while (hready !== 1'b1 && i < 100);
    #1 rd = rdq;
    if (i >= 50 || hresp !== 1'b0) begin
      errors++;
      end_of_test();
    end
  endtask
  // ----
  // expected status word
  // ----
  function automatic logic [31:0] exp_st(logic [7:0] p, e, r, logic [17:0] c);
    logic da, db, act, ch;
    logic [7:0] ex, k, s, m;
    da = c[16] ? p[1] : p[0];
    db = c[17] ? p[0] : p[1];
    act = c[0] & ~(p[0] & p[1]) & ~da;
    ex = {e[7:1], 1'b0};
    ch = 1;
    for (int n = 0; n < 8; n++) begin
      k[n] = (r[n] | ex[n]) & act;
      ch = ch & k[n];
      s[n] = ch & (r[n] | ex[n] & e[0]);
      m[n] = k[n] & ex[n] & ~r[n] & (c[7:4] == 4'h0 || c[7:4] == 4'h5);
    end
    return {m, s, k, 2'h0, db & ~(p[0] & p[1]) & ~da, p[0] & p[1], db, da, p[1], p[0]};
  endfunction
  // ----
  // main sequence
  // ----
  initial begin
    logic [31:0] rd, st;
    logic [7:0] p, e, r;
    logic [17:0] c;
    logic [7:0] cp[4] = '{8'h00, 8'h02, 8'h03, 8'hfc}; // no channel, b only, both, then none down with reserved bits set
    logic [7:0] ce[4] = '{8'hff, 8'h00, 8'hff, 8'hfe};
    logic [7:0] cr[4] = '{8'h01, 8'h05, 8'h0f, 8'h00};
    rd = $urandom(90);
    repeat (20) @(posedge clk);
    resetn <= 1;
    xfer(1, 10'h20b, 32'hffffffff, rd);
    for (int i = 0; i < 8; i++) begin
      xfer(0, 10'h208 + 10'(i), 0, rd);
      `CHK(rd, 32'h0)
    end
    for (int k = 0; k < 60; k++) begin
      p = 8'($urandom);
      e = 8'($urandom);
      r = 8'($urandom);
      c = 18'($urandom);
      c[0] = ($urandom % 4) != 0;
      if ($urandom % 2) c[7:4] = ($urandom % 2) ? 4'h0 : 4'h5;
      if (k < 4) begin
        p = cp[k];
        e = ce[k];
        r = cr[k];
        c = (k == 3) ? 18'h00051 : 18'h00001;
      end
      xfer(1, `IDX_LINK_CONFIG, {c[17:1], 1'b0}, rd);
      xfer(1, `IDX_CHANNEL_POWER_DOWN, {24'h0, p}, rd);
      xfer(1, `IDX_EXTRA_LANE_A, {24'h0, e}, rd);
      xfer(1, `IDX_LANE_REQUIRED_A, {24'h0, r}, rd);
      xfer(1, `IDX_LINK_CONFIG, {14'h0, c}, rd);
      repeat (3) @(posedge clk);
      st = exp_st(p, e, r, c);
      `CHK({rp, se, ck, 2'h0, bs, sub, dB, dA, cB, cA}, st)
      `CHK({len, lms, lts}, {c[0] & ~st[4], c[15:8], c[7:4]})
      if (c[0] && !st[4] && !st[2])
        for (int n = 0; n < 8; n++) `CHK(lpat[4*n+:4], st[24+n] ? 4'h4 : c[7:4])
      xfer(0, `IDX_BLOCK_STATUS, 0, rd);
      `CHK(rd, st)
      xfer(0, `IDX_CHANNEL_POWER_DOWN, 0, rd);
      `CHK(rd, {24'h0, p})
    end
    // second reset in mid-run clears every register
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 1; i < 7; i++) begin
      xfer(0, 10'h208 + 10'(i), 0, rd);
      `CHK(rd, 32'h0)
    end
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
